// ### pkg/spg_pkg.sv
package spg_pkg;

  // ********************************************************************
  // Geometry
  // ********************************************************************
  localparam int unsigned AW = 13;
  localparam int unsigned DW = 16;
  localparam int unsigned CMD_W = 5;
  // Lowest word address of the no-read-while-write region
  localparam logic [AW-1:0] FIXED_SPLIT_ADDR = 13'h1800;
  // Boot region start per boot size fuses; every entry lies at or above FIXED_SPLIT_ADDR
  localparam logic [3:0][AW-1:0] BOOT_START_TBL = {13'h1f00, 13'h1e00, 13'h1c00, 13'h1800};
  localparam logic [AW-1:0] APP_RESET_VECTOR = 13'h0000;

  // ********************************************************************
  // Control commands (low five control bits)
  // ********************************************************************
  localparam logic [CMD_W-1:0] CMD_FILL = 5'h01;
  localparam logic [CMD_W-1:0] CMD_ERASE = 5'h03;
  localparam logic [CMD_W-1:0] CMD_WRITE = 5'h05;
  localparam logic [CMD_W-1:0] CMD_LOCK = 5'h09;
  localparam logic [CMD_W-1:0] CMD_RD_EN = 5'h11;
  localparam int unsigned ARM_CYCLES = 4;

  // ********************************************************************
  // Lock fields
  // ********************************************************************
  localparam int unsigned R0_APP_LSB = 2;
  localparam int unsigned R0_BOOT_LSB = 4;
  localparam int unsigned LOCK_WR_BIT = 0;
  localparam int unsigned LOCK_RD_BIT = 1;
  localparam logic [1:0] LOCK_UNPRG = 2'h3;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [2:0] {OP_NONE, OP_FILL, OP_ERASE, OP_WRITE, OP_LOCK, OP_BUF_CLR} spg_op_type;

  typedef struct packed {
    spg_op_type op;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } spg_flash_req_type;

  typedef struct packed {
    logic [1:0] boot;
    logic [1:0] app;
  } spg_locks_type;

  localparam spg_locks_type LOCKS_RESET = {LOCK_UNPRG, LOCK_UNPRG};
  localparam spg_flash_req_type FLASH_REQ_RESET = {OP_NONE, 13'h0000, 16'h0000};

endpackage

// ### verif/spg_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module spg_flash_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Start and latency in cycles, at least one
  input wire logic start,
  input wire logic [7:0] lat,
  // Completion pulse
  output logic done
);
  logic [7:0] cnt_ff;
  logic busy_ff;

  // One done pulse per started operation, after lat cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      busy_ff <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_ff <= 1'b1;
        cnt_ff <= 8'h01;
      end else if (busy_ff && cnt_ff >= lat) begin
        busy_ff <= 1'b0;
        done <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import spg_pkg::*;
  logic clk, rst_n, ctrl_wr, spm_exec, rd_req, rd_is_table, rd_ack, rd_undef, rd_deny;
  logic [4:0] ctrl_data;
  logic [12:0] spm_pc, spm_addr, rd_pc, rd_addr, reset_vector;
  logic [15:0] spm_data;
  logic [1:0] boot_size;
  logic boot_reset, ext_lock_prg, chip_erase, flash_start, flash_done;
  logic cpu_halt, region_busy, enable_status;
  logic [7:0] lat;
  spg_locks_type nv_locks, ext_lock_data, locks;
  spg_flash_req_type flash_req;
  int mismatches = 0;
  int num_checks = 0;
  localparam logic [2:0] NONE = 3'h0;
  localparam logic [2:0] ACK = 3'h4;
  localparam logic [2:0] UNDEF = 3'h2;
  localparam logic [2:0] DENY = 3'h1;

  spg_guard dut (.CLK(clk), .RST_N(rst_n), .CTRL_WR(ctrl_wr), .CTRL_DATA(ctrl_data),
    .SPM_EXEC(spm_exec), .SPM_PC(spm_pc), .SPM_ADDR(spm_addr), .SPM_DATA(spm_data),
    .RD_REQ(rd_req), .RD_IS_TABLE(rd_is_table), .RD_PC(rd_pc), .RD_ADDR(rd_addr),
    .RD_ACK(rd_ack), .RD_UNDEF(rd_undef), .RD_DENY(rd_deny), .BOOT_SIZE_FUSES(boot_size),
    .BOOT_RESET_FUSE(boot_reset), .NV_LOCKS(nv_locks), .EXT_LOCK_PRG(ext_lock_prg),
    .EXT_LOCK_DATA(ext_lock_data), .CHIP_ERASE(chip_erase), .FLASH_REQ(flash_req),
    .FLASH_START(flash_start), .FLASH_DONE(flash_done), .CPU_HALT(cpu_halt),
    .REGION_BUSY(region_busy), .ENABLE_STATUS(enable_status), .LOCKS(locks),
    .RESET_VECTOR(reset_vector));
  spg_flash_model u_flash (.clk(clk), .rst_n(rst_n), .start(flash_start), .lat(lat),
    .done(flash_done));

  always #5 clk = ~clk;

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic fuse, input logic [1:0] sz);
    @(posedge clk);
    boot_reset <= fuse;
    boot_size <= sz;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Control write, then the store sampled d edges later
  task automatic store(input logic [4:0] code, input int d, input logic [12:0] pc, addr,
                       input logic [15:0] data, input logic exp_go, input spg_op_type op);
    @(posedge clk);
    ctrl_wr <= 1'b1;
    ctrl_data <= code;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    repeat (d - 1) @(posedge clk);
    spm_exec <= 1'b1;
    spm_pc <= pc;
    spm_addr <= addr;
    spm_data <= data;
    @(posedge clk);
    spm_exec <= 1'b0;
    #1;
    chk("flash start", 32'(exp_go), 32'(flash_start));
    if (exp_go) begin
      chk("flash op", 32'(op), 32'(flash_req.op));
      chk("flash word", 32'({addr, data}), 32'({flash_req.addr, flash_req.data}));
      chk("enable", 32'h1, 32'(enable_status));
    end
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (enable_status !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("op finished", 32'h1, 32'(n < 200));
  endtask

  task automatic rd(input logic tbl, input logic [12:0] pc, addr, input logic [2:0] exp);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_is_table <= tbl;
    rd_pc <= pc;
    rd_addr <= addr;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    chk("read answer", 32'(exp), 32'({rd_ack, rd_undef, rd_deny}));
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_vectors;
    for (int i = 0; i < 4; i++) begin
      do_reset(1'b0, 2'(i));
      chk("boot vector", 32'(BOOT_START_TBL[i]), 32'(reset_vector));
    end
    do_reset(1'b1, 2'h3);
    chk("app vector", 32'(APP_RESET_VECTOR), 32'(reset_vector));
  endtask

  task automatic t_codes;
    logic [4:0] code [5] = '{5'h01, 5'h03, 5'h05, 5'h09, 5'h11};
    spg_op_type op [5] = '{OP_FILL, OP_ERASE, OP_WRITE, OP_LOCK, OP_BUF_CLR};
    lat <= 8'h01;
    for (int i = 0; i < 5; i++) begin
      store(code[i], 1, 13'h1f00, 13'h1900, 16'hffff, 1'b1, op[i]);
      wait_idle();
    end
    store(5'h07, 1, 13'h1f00, 13'h1900, 16'hffff, 1'b0, OP_NONE);
    store(5'h03, 1, 13'h0100, 13'h0200, 16'hffff, 1'b0, OP_NONE);
    store(5'h03, 5, 13'h1f00, 13'h1900, 16'hffff, 1'b0, OP_NONE);
    store(5'h03, 4, 13'h1f00, 13'h1900, 16'hffff, 1'b1, OP_ERASE);
    wait_idle();
  endtask

  task automatic t_halt;
    lat <= 8'h14;
    store(5'h03, 2, 13'h1f00, 13'h1f40, 16'hffff, 1'b1, OP_ERASE);
    chk("halt", 32'h1, 32'(cpu_halt));
    chk("busy", 32'h0, 32'(region_busy));
    rd(1'b0, 13'h1f00, 13'h1f10, NONE);
    wait_idle();
    chk("halt end", 32'h0, 32'(cpu_halt));
  endtask

  task automatic t_rww;
    lat <= 8'h14;
    store(5'h05, 3, 13'h1f00, 13'h0100, 16'hffff, 1'b1, OP_WRITE);
    chk("halt", 32'h0, 32'(cpu_halt));
    chk("busy", 32'h1, 32'(region_busy));
    rd(1'b0, 13'h1f00, 13'h1f10, ACK);
    rd(1'b0, 13'h1f00, 13'h0140, UNDEF);
    rd(1'b1, 13'h1f00, 13'h0200, UNDEF);
    wait_idle();
    chk("busy held", 32'h1, 32'(region_busy));
    // Software clears the flag before touching the region again
    store(5'h11, 1, 13'h1f00, 13'h0000, 16'hffff, 1'b1, OP_BUF_CLR);
    wait_idle();
    chk("busy clear", 32'h0, 32'(region_busy));
    rd(1'b0, 13'h1f00, 13'h0100, ACK);
  endtask

  task automatic t_locks;
    lat <= 8'h02;
    nv_locks <= 4'b1011;
    do_reset(1'b1, 2'h3);
    chk("locks", 32'h0000000b, 32'(locks));
    store(5'h03, 1, 13'h1f00, 13'h1f40, 16'hffff, 1'b0, OP_NONE);
    store(5'h03, 1, 13'h1f00, 13'h0100, 16'hffff, 1'b1, OP_ERASE);
    wait_idle();
    store(5'h11, 1, 13'h1f00, 13'h0000, 16'hffff, 1'b1, OP_BUF_CLR);
    wait_idle();
    store(5'h09, 1, 13'h1f00, 13'h0001, 16'h00fb, 1'b1, OP_LOCK);
    wait_idle();
    chk("locks set", 32'h0000000a, 32'(locks));
    rd(1'b1, 13'h1f00, 13'h0100, ACK);
    @(posedge clk);
    ext_lock_prg <= 1'b1;
    ext_lock_data <= 4'b1101;
    @(posedge clk);
    ext_lock_prg <= 1'b0;
    #1;
    chk("locks ext", 32'h00000008, 32'(locks));
    rd(1'b1, 13'h1f00, 13'h0100, DENY);
    rd(1'b1, 13'h0100, 13'h0200, ACK);
    rd(1'b0, 13'h1f00, 13'h0100, ACK);
    @(posedge clk);
    chip_erase <= 1'b1;
    @(posedge clk);
    chip_erase <= 1'b0;
    #1;
    chk("locks erased", 32'h0000000f, 32'(locks));
  endtask

  // ********************************************************************
  // Main sequence and watchdog
  // ********************************************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {ctrl_wr, spm_exec, rd_req, rd_is_table, ext_lock_prg, chip_erase} = 6'h00;
    ctrl_data = 5'h00;
    {spm_pc, spm_addr, rd_pc, rd_addr} = 52'h0;
    spm_data = 16'h0000;
    boot_size = 2'h3;
    boot_reset = 1'b1;
    nv_locks = 4'hf;
    ext_lock_data = 4'hf;
    lat = 8'h01;
    t_vectors();
    t_codes();
    t_halt();
    t_rww();
    t_locks();
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire

// ### verilog/spg_arm_timer.sv
`timescale 1ns/10ps
`default_nettype none
module spg_arm_timer #(
  parameter int unsigned CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Arm and consume
  input wire logic load,
  input wire logic consume,
  // Window open
  output logic armed
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD_VAL = W'(CYCLES);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // ********************************************************************
  // Window counter
  // ********************************************************************
  // A fresh load wins over a store in the same cycle
  assign nxt_cnt = load ? LOAD_VAL :
                   consume ? '0 :
                   (cnt_ff != '0) ? cnt_ff - W'(1) : cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign armed = cnt_ff != '0;

  // ********************************************************************
  // Checks
  // ********************************************************************
  arm_window_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      load ##1 (!load && !consume) [*4] |-> armed)
    else $error("Store window closed before four cycles");

  arm_lapse_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      load ##1 (!load) [*4] |=> !armed)
    else $error("Store window still open after four cycles");

endmodule
`default_nettype wire

// ### verilog/spg_guard.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Ignore program stores fetched from application region
// - Program stores start only from boot region
// - Boot code may target any flash page
// - CPU runs, other region served during busy
// - Halt CPU while programming no-read-while-write region
// - Block read-while-write reads while it programs
// - Boot region always inside no-read-while-write region
// - Busy flag reads one while region blocked
// - Split flash by boot size and boundary
// - Lock set zero guards application, one boot
// - Locks only programmed; chip erase unprograms them
// - General lock mode 2 ignored for stores
// - General lock mode 1 ignored for accesses
// - Bit one is unprogrammed, zero programmed
// - Fuse one: reset to application address zero
// - Fuse zero: reset to boot start address
// - No self-programming path alters fuse bits
// - Enable bit arms stores for four cycles
module spg_guard (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Control register write
  input wire logic CTRL_WR,
  input wire logic [spg_pkg::CMD_W-1:0] CTRL_DATA,
  // Program store execution
  input wire logic SPM_EXEC,
  input wire logic [spg_pkg::AW-1:0] SPM_PC,
  input wire logic [spg_pkg::AW-1:0] SPM_ADDR,
  input wire logic [spg_pkg::DW-1:0] SPM_DATA,
  // Fetch and table read
  input wire logic RD_REQ,
  input wire logic RD_IS_TABLE,
  input wire logic [spg_pkg::AW-1:0] RD_PC,
  input wire logic [spg_pkg::AW-1:0] RD_ADDR,
  output logic RD_ACK,
  output logic RD_UNDEF,
  output logic RD_DENY,
  // Fuses and lock bits
  input wire logic [1:0] BOOT_SIZE_FUSES,
  input wire logic BOOT_RESET_FUSE,
  input wire spg_pkg::spg_locks_type NV_LOCKS,
  input wire logic EXT_LOCK_PRG,
  input wire spg_pkg::spg_locks_type EXT_LOCK_DATA,
  input wire logic CHIP_ERASE,
  // Flash array
  output var spg_pkg::spg_flash_req_type FLASH_REQ,
  output logic FLASH_START,
  input wire logic FLASH_DONE,
  // Status
  output logic CPU_HALT,
  output logic REGION_BUSY,
  output logic ENABLE_STATUS,
  output var spg_pkg::spg_locks_type LOCKS,
  output logic [spg_pkg::AW-1:0] RESET_VECTOR
);
  import spg_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_LOW_PRG, ST_HIGH_PRG} spg_state_type;

  spg_state_type state_ff;
  spg_state_type nxt_state;
  logic [CMD_W-1:0] cmd_ff;
  logic busy_ff;
  logic halt_ff;
  logic enable_ff;
  logic loaded_ff;
  spg_locks_type locks_ff;
  spg_flash_req_type req_ff;
  logic start_ff;
  logic rd_ack_ff;
  logic rd_undef_ff;
  logic rd_deny_ff;
  logic [AW-1:0] vector_ff;
  logic armed;
  logic app_wr_ok;
  logic app_rd_ok;
  logic boot_wr_ok;
  logic boot_rd_ok;

  // ********************************************************************
  // Region decode
  // ********************************************************************
  wire logic [AW-1:0] boot_start = BOOT_START_TBL[BOOT_SIZE_FUSES];
  wire logic pc_in_boot = SPM_PC >= boot_start;
  wire logic tgt_in_boot = SPM_ADDR >= boot_start;
  wire logic tgt_low = SPM_ADDR < FIXED_SPLIT_ADDR;

  // ********************************************************************
  // Command arming
  // ********************************************************************
  wire logic idle = state_ff == ST_IDLE;
  wire logic cmd_known = (CTRL_DATA == CMD_FILL) || (CTRL_DATA == CMD_ERASE) ||
                         (CTRL_DATA == CMD_WRITE) || (CTRL_DATA == CMD_LOCK) ||
                         (CTRL_DATA == CMD_RD_EN);
  // Other codes leave the arm state untouched
  wire logic arm_load = CTRL_WR && cmd_known && idle;
  wire logic spm_try = SPM_EXEC && armed && idle;

  spg_arm_timer #(
    .CYCLES(ARM_CYCLES)
  ) u_arm (
    .clk(CLK),
    .rst_n(RST_N),
    .load(arm_load),
    .consume(SPM_EXEC && idle),
    .armed(armed)
  );

  // ********************************************************************
  // Store acceptance
  // ********************************************************************
  spg_lock_decode u_app_dec (
    .field(locks_ff.app),
    .wr_ok(app_wr_ok),
    .rd_ok(app_rd_ok)
  );

  spg_lock_decode u_boot_dec (
    .field(locks_ff.boot),
    .wr_ok(boot_wr_ok),
    .rd_ok(boot_rd_ok)
  );

  // The target region's lock field, boot or application, gates erase and write stores; general lock modes are not inputs here
  wire logic tgt_wr_ok = tgt_in_boot ? boot_wr_ok : app_wr_ok;
  wire logic is_page_op = (cmd_ff == CMD_ERASE) || (cmd_ff == CMD_WRITE);
  // Page ops reach any page, boot region included, when its lock allows
  wire logic spm_go = spm_try && pc_in_boot && (!is_page_op || tgt_wr_ok);
  wire logic low_go = spm_go && is_page_op && tgt_low;
  wire logic high_go = spm_go && is_page_op && !tgt_low;
  wire logic lock_go = spm_go && (cmd_ff == CMD_LOCK);
  wire logic rden_go = spm_go && (cmd_ff == CMD_RD_EN);
  wire spg_op_type go_op = (cmd_ff == CMD_ERASE) ? OP_ERASE :
                           (cmd_ff == CMD_WRITE) ? OP_WRITE :
                           (cmd_ff == CMD_LOCK) ? OP_LOCK :
                           (cmd_ff == CMD_RD_EN) ? OP_BUF_CLR : OP_FILL;
  wire spg_flash_req_type nxt_req = spm_go ? {go_op, SPM_ADDR, SPM_DATA} : req_ff;

  // ********************************************************************
  // Operation sequencing
  // ********************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (low_go) begin
          nxt_state = ST_LOW_PRG;
        end else if (high_go) begin
          nxt_state = ST_HIGH_PRG;
        end else if (spm_go) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN, ST_LOW_PRG, ST_HIGH_PRG: begin
        if (FLASH_DONE) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Flag stays up after the operation until software re-enables the region
  wire logic nxt_busy = low_go ? 1'b1 : (rden_go ? 1'b0 : busy_ff);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_IDLE;
      cmd_ff <= '0;
      busy_ff <= 1'b0;
      halt_ff <= 1'b0;
      enable_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= arm_load ? CTRL_DATA : cmd_ff;
      busy_ff <= nxt_busy;
      halt_ff <= nxt_state == ST_HIGH_PRG;
      enable_ff <= armed || !idle;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_ff <= FLASH_REQ_RESET;
      start_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      start_ff <= spm_go;
    end
  end

  // ********************************************************************
  // Lock bits
  // ********************************************************************
  // Stored levels are taken on the first edge after reset release
  wire spg_locks_type ext_mask = EXT_LOCK_PRG ? EXT_LOCK_DATA : LOCKS_RESET;
  wire spg_locks_type spm_mask = lock_go ?
    {SPM_DATA[R0_BOOT_LSB +: 2], SPM_DATA[R0_APP_LSB +: 2]} : LOCKS_RESET;
  // Programming only clears bits; only chip erase returns them to one
  wire spg_locks_type nxt_locks = !loaded_ff ? NV_LOCKS :
                                  CHIP_ERASE ? LOCKS_RESET :
                                  spg_locks_type'(locks_ff & ext_mask & spm_mask);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      loaded_ff <= 1'b0;
      locks_ff <= LOCKS_RESET;
    end else begin
      loaded_ff <= 1'b1;
      locks_ff <= nxt_locks;
    end
  end

  // ********************************************************************
  // Reset vector
  // ********************************************************************
  // Fuses are inputs only, so no store can alter them
  wire logic [AW-1:0] nxt_vector = BOOT_RESET_FUSE ? APP_RESET_VECTOR : boot_start;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vector_ff <= APP_RESET_VECTOR;
    end else begin
      vector_ff <= nxt_vector;
    end
  end

  // ********************************************************************
  // Read gating
  // ********************************************************************
  wire logic rd_pc_boot = RD_PC >= boot_start;
  wire logic rd_tgt_boot = RD_ADDR >= boot_start;
  wire logic rd_tgt_low = RD_ADDR < FIXED_SPLIT_ADDR;
  // Software is expected to keep away; a stray access just gets no data
  wire logic rd_blocked = busy_ff && rd_tgt_low;
  wire logic rd_cross_ok = (rd_pc_boot == rd_tgt_boot) ||
                           (rd_tgt_boot ? boot_rd_ok : app_rd_ok);
  wire logic rd_live = RD_REQ && !halt_ff;
  wire logic rd_deny = rd_live && !rd_blocked && RD_IS_TABLE && !rd_cross_ok;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_ack_ff <= 1'b0;
      rd_undef_ff <= 1'b0;
      rd_deny_ff <= 1'b0;
    end else begin
      rd_ack_ff <= rd_live && !rd_blocked && !rd_deny;
      rd_undef_ff <= rd_live && rd_blocked;
      rd_deny_ff <= rd_deny;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign RD_ACK = rd_ack_ff;
  assign RD_UNDEF = rd_undef_ff;
  assign RD_DENY = rd_deny_ff;
  assign FLASH_REQ = req_ff;
  assign FLASH_START = start_ff;
  assign CPU_HALT = halt_ff;
  assign REGION_BUSY = busy_ff;
  assign ENABLE_STATUS = enable_ff;
  assign LOCKS = locks_ff;
  assign RESET_VECTOR = vector_ff;

  // ********************************************************************
  // Checks
  // ********************************************************************
  app_spm_ignored_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      spm_try && !pc_in_boot |=> !FLASH_START && (state_ff == ST_IDLE))
    else $error("Store from application region started an operation");

  boot_spm_start_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      spm_go |=> FLASH_START && (FLASH_REQ.op == $past(go_op)))
    else $error("Accepted boot store did not start the flash");

  any_page_target_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      spm_try && pc_in_boot && is_page_op && tgt_in_boot && boot_wr_ok
      |=> FLASH_START && (FLASH_REQ.addr == $past(SPM_ADDR)))
    else $error("Boot store could not target the boot region");

  low_prg_runs_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      (state_ff == ST_LOW_PRG) && RD_REQ && !rd_tgt_low && !rd_deny |=> RD_ACK && !CPU_HALT)
    else $error("Other region not served during busy-region programming");

  high_prg_halt_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      high_go ##1 (!FLASH_DONE) [*3] |-> CPU_HALT && $past(CPU_HALT, 2))
    else $error("CPU not halted through programming");

  busy_read_block_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      RD_REQ && REGION_BUSY && rd_tgt_low && !CPU_HALT |=> RD_UNDEF && !RD_ACK)
    else $error("Read of busy region was served");

  boot_above_split_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      (boot_start >= FIXED_SPLIT_ADDR) &&
      ((RESET_VECTOR == APP_RESET_VECTOR) || (RESET_VECTOR >= FIXED_SPLIT_ADDR)))
    else $error("Boot region reaches below the fixed boundary");

  busy_flag_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      low_go ##1 ((state_ff == ST_LOW_PRG) || !rden_go) [*2] |=> REGION_BUSY)
    else $error("Busy flag dropped while region blocked");

  lock_gate_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      spm_try && is_page_op && !tgt_wr_ok |=> !FLASH_START)
    else $error("Locked region accepted a page operation");

  lock_no_clear_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      loaded_ff && !CHIP_ERASE |=> ((4'(LOCKS) & ~4'($past(LOCKS))) == 4'h0))
    else $error("Lock bit unprogrammed without chip erase");

  app_vector_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      BOOT_RESET_FUSE |=> RESET_VECTOR == APP_RESET_VECTOR)
    else $error("Reset vector not application start");

  boot_vector_a:
    assert property (@(posedge CLK) disable iff (!RST_N)
      RST_N && !BOOT_RESET_FUSE |=> RESET_VECTOR == $past(boot_start))
    else $error("Reset vector not boot start");

endmodule
`default_nettype wire

// ### verilog/spg_lock_decode.sv
`timescale 1ns/10ps
`default_nettype none
module spg_lock_decode (
  // Two-bit lock field, a zero bit is programmed
  input wire logic [1:0] field,
  // Permissions
  output logic wr_ok,
  output logic rd_ok
);
  import spg_pkg::*;

  // ********************************************************************
  // Mode decode
  // ********************************************************************
  // 11 free, 10 no stores, 01 no table reads, 00 neither
  assign wr_ok = field[LOCK_WR_BIT];
  assign rd_ok = field[LOCK_RD_BIT];

endmodule
`default_nettype wire
